// *** shared/cfr_pkg.sv ***
// Package for the controller's host register bank: offsets, reset values,
// field positions and the carrier structs.
// Assumes a single host clock; protocol-side status arrives from a slower domain.
package cfr_pkg;

   // ----------------------------------------------------------------
   // Window geometry
   // ----------------------------------------------------------------
   localparam logic [31:0] BASE_ADDR = 32'h0470_1000;
   localparam int ADDR_W = 8;
   localparam int WORDS = 64;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses inside the window)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_RELEASE = 8'h00;
   localparam logic [7:0] OFS_PROBE = 8'h04;
   localparam logic [7:0] OFS_FAST_BT = 8'h0c;
   localparam logic [7:0] OFS_TEST = 8'h10;
   localparam logic [7:0] OFS_RAM_WDG = 8'h14;
   localparam logic [7:0] OFS_CORE_CTRL = 8'h18;
   localparam logic [7:0] OFS_NOM_BT = 8'h1c;
   localparam logic [7:0] OFS_TS_CFG = 8'h20;
   localparam logic [7:0] OFS_TS_VAL = 8'h24;
   localparam logic [7:0] OFS_TO_CFG = 8'h28;
   localparam logic [7:0] OFS_TO_VAL = 8'h2c;
   localparam logic [7:0] OFS_ERR_CNT = 8'h40;
   localparam logic [7:0] OFS_PROT_STAT = 8'h44;
   localparam logic [7:0] OFS_TDC = 8'h48;
   localparam logic [7:0] OFS_IRQ_FLAGS = 8'h50;
   localparam logic [7:0] OFS_IRQ_EN = 8'h54;
   localparam logic [7:0] OFS_IRQ_SEL = 8'h58;
   localparam logic [7:0] OFS_IRQ_LINE_EN = 8'h5c;
   localparam logic [7:0] OFS_GFC = 8'h80;
   localparam logic [7:0] OFS_SIDFC = 8'h84;
   localparam logic [7:0] OFS_XIDFC = 8'h88;
   localparam logic [7:0] OFS_XIDAM = 8'h90;
   localparam logic [7:0] OFS_HPMS = 8'h94;
   localparam logic [7:0] OFS_NDAT1 = 8'h98;
   localparam logic [7:0] OFS_NDAT2 = 8'h9c;
   localparam logic [7:0] OFS_RXQ0_CFG = 8'ha0;
   localparam logic [7:0] OFS_RXQ0_STAT = 8'ha4;
   localparam logic [7:0] OFS_RXQ0_ACK = 8'ha8;
   localparam logic [7:0] OFS_RXB_CFG = 8'hac;
   localparam logic [7:0] OFS_RXQ1_CFG = 8'hb0;
   localparam logic [7:0] OFS_RXQ1_STAT = 8'hb4;
   localparam logic [7:0] OFS_RXQ1_ACK = 8'hb8;
   localparam logic [7:0] OFS_RX_ESC = 8'hbc;
   localparam logic [7:0] OFS_TXB_CFG = 8'hc0;
   localparam logic [7:0] OFS_TXQ_STAT = 8'hc4;
   localparam logic [7:0] OFS_TX_ESC = 8'hc8;
   localparam logic [7:0] OFS_TX_PEND = 8'hcc;
   localparam logic [7:0] OFS_TX_ADD = 8'hd0;
   localparam logic [7:0] OFS_TX_CANCEL = 8'hd4;
   localparam logic [7:0] OFS_TX_DONE = 8'hd8;
   localparam logic [7:0] OFS_TX_CDONE = 8'hdc;
   localparam logic [7:0] OFS_TX_DONE_IE = 8'he0;
   localparam logic [7:0] OFS_TX_CDONE_IE = 8'he4;
   localparam logic [7:0] OFS_TXEQ_CFG = 8'hf0;
   localparam logic [7:0] OFS_TXEQ_STAT = 8'hf4;
   localparam logic [7:0] OFS_TXEQ_ACK = 8'hf8;

   // ----------------------------------------------------------------
   // Reset values and fixed words
   // ----------------------------------------------------------------
   localparam logic [31:0] PROBE_WORD = 32'h8765_4321;
   localparam logic [31:0] RST_FAST_BT = 32'h0000_0a33;
   localparam logic [31:0] RST_TEST = 32'h0000_0080;
   localparam logic [31:0] RST_CORE_CTRL = 32'h0000_0001;
   localparam logic [31:0] RST_NOM_BT = 32'h0600_0a03;
   localparam logic [31:0] RST_TO_CFG = 32'hffff_0000;
   localparam logic [15:0] RST_TO_VAL = 16'hffff;
   localparam logic [31:0] RST_XIDAM = 32'h1fff_ffff;
   localparam logic [2:0] LEC_NO_CHANGE = 3'h7;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CC_INIT = 0;
   localparam int CC_CCE = 1;
   localparam int TS_SEL_LSB = 0;
   localparam logic [1:0] TS_SEL_INC = 2'h1;
   localparam int TO_EN = 0;
   localparam int TO_PERIOD_LSB = 16;
   localparam int ILE_LINE_A = 0;
   localparam int ILE_LINE_B = 1;

   // ----------------------------------------------------------------
   // Access sizes of the slave port
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CFR_SZ_BYTE, CFR_SZ_HALF, CFR_SZ_WORD} cfr_size_t;

   typedef struct packed {
      logic bus_off;
      logic warning;
      logic passive;
      logic [1:0] activity;
      logic rx_passive;
      logic [7:0] tx_err;
      logic [6:0] rx_err;
   } cfr_status_t;

   typedef struct packed {
      logic init;
      logic cfg_change;
      logic [31:0] core_ctrl;
      logic [31:0] nom_bt;
      logic [31:0] fast_bt;
      logic [31:0] test;
      logic [31:0] tdc;
      logic [15:0] timestamp;
   } cfr_cfg_t;

endpackage

// *** logic/cfr_regbank.sv ***
// Host register bank of the CAN FD controller: 256-byte window, byte/half/word
// access, protected writes, read and write side effects, interrupt routing.
// Assumes slave port inputs synchronous to core_clk_i; protocol status levels
// and toggle events come from the protocol clock domain and are synchronised.
//
// Function
// - Reset loads every register initial value
// - Reset releases bus-off, transmit pin recessive
// - Core control resets 0x0001, init set
// - Init set keeps bus undisturbed
// - Decode 256-byte register window
// - Every register is a 32-bit word
// - Byte, half-word and word accesses accepted
// - Protected writes need change-enable and init
// - Status lags command writes by sync delay
// - Reserved offsets ignore writes, read zero
// - Read clears or sets read-effect fields
// - Counter value writes clear or preset
// - Window based at fixed system address
// - Byte-order probe reads fixed word
// - Synchronise status between clock domains
// - Sources default to line A, line enables
`timescale 1ns/1ps
module cfr_regbank #(
   parameter logic [31:0] RELEASE_INFO = 32'h1000_0001, // Arbitrary value
   parameter int HS_WORDS = 8
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic bus_sel_i,
   input wire logic bus_wr_i,
   input wire logic [7:0] bus_addr_i,
   input wire cfr_pkg::cfr_size_t bus_size_i,
   input wire logic [31:0] bus_wdata_i,
   output logic [31:0] bus_rdata_o,
   output logic bus_rvalid_o,
   input wire cfr_pkg::cfr_status_t proto_status_i,
   input wire logic [2:0] proto_lec_i,
   input wire logic proto_lec_tgl_i,
   input wire logic [2:0] proto_dlec_i,
   input wire logic proto_dlec_tgl_i,
   input wire logic proto_errlog_tgl_i,
   input wire logic [31:0] handler_word_i [HS_WORDS],
   input wire logic [31:0] irq_event_i,
   input wire logic ts_tick_i,
   input wire logic to_tick_i,
   input wire logic proto_tx_i,
   output logic bus_transmit_pin_o,
   output logic irq_line_a_o,
   output logic irq_line_b_o,
   output logic [31:0] tx_add_pulse_o,
   output cfr_pkg::cfr_cfg_t cfg_o
);

   // ----------------------------------------------------------------
   // Address classification
   // ----------------------------------------------------------------
   function automatic logic [31:0] rst_val(input logic [7:0] ofs);
      case (ofs)
         cfr_pkg::OFS_FAST_BT: rst_val = cfr_pkg::RST_FAST_BT;
         cfr_pkg::OFS_TEST: rst_val = cfr_pkg::RST_TEST;
         cfr_pkg::OFS_CORE_CTRL: rst_val = cfr_pkg::RST_CORE_CTRL;
         cfr_pkg::OFS_NOM_BT: rst_val = cfr_pkg::RST_NOM_BT;
         cfr_pkg::OFS_TO_CFG: rst_val = cfr_pkg::RST_TO_CFG;
         cfr_pkg::OFS_XIDAM: rst_val = cfr_pkg::RST_XIDAM;
         default: rst_val = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic is_protected(input logic [7:0] ofs);
      case (ofs)
         cfr_pkg::OFS_FAST_BT, cfr_pkg::OFS_TEST, cfr_pkg::OFS_RAM_WDG,
         cfr_pkg::OFS_NOM_BT, cfr_pkg::OFS_TS_CFG, cfr_pkg::OFS_TO_CFG,
         cfr_pkg::OFS_TDC, cfr_pkg::OFS_GFC, cfr_pkg::OFS_SIDFC,
         cfr_pkg::OFS_XIDFC, cfr_pkg::OFS_XIDAM, cfr_pkg::OFS_RXQ0_CFG,
         cfr_pkg::OFS_RXB_CFG, cfr_pkg::OFS_RXQ1_CFG, cfr_pkg::OFS_RX_ESC,
         cfr_pkg::OFS_TXB_CFG, cfr_pkg::OFS_TX_ESC, cfr_pkg::OFS_TXEQ_CFG:
            is_protected = 1'b1;
         default: is_protected = 1'b0;
      endcase
   endfunction

   function automatic logic is_plain_rw(input logic [7:0] ofs);
      case (ofs)
         cfr_pkg::OFS_IRQ_EN, cfr_pkg::OFS_IRQ_SEL, cfr_pkg::OFS_IRQ_LINE_EN,
         cfr_pkg::OFS_NDAT1, cfr_pkg::OFS_NDAT2, cfr_pkg::OFS_RXQ0_ACK,
         cfr_pkg::OFS_RXQ1_ACK, cfr_pkg::OFS_TX_ADD, cfr_pkg::OFS_TX_CANCEL,
         cfr_pkg::OFS_TX_DONE_IE, cfr_pkg::OFS_TX_CDONE_IE, cfr_pkg::OFS_TXEQ_ACK:
            is_plain_rw = 1'b1;
         default: is_plain_rw = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] lane_mask(input cfr_pkg::cfr_size_t sz,
                                             input logic [1:0] lo);
      case (sz)
         cfr_pkg::CFR_SZ_BYTE: lane_mask = 32'h0000_00ff << {lo, 3'h0};
         cfr_pkg::CFR_SZ_HALF: lane_mask = lo[1] ? 32'hffff_0000 : 32'h0000_ffff;
         default: lane_mask = 32'hffff_ffff;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   logic [5:0] widx;
   logic [7:0] wofs;
   logic wr_take;
   logic rd_take;
   logic [31:0] bmask;
   logic prot_ok;
   logic [31:0] regs_ff [cfr_pkg::WORDS];
   logic [31:0] merged;

   assign widx = bus_addr_i[7:2];
   assign wofs = {widx, 2'h0};
   assign wr_take = bus_sel_i & bus_wr_i;
   assign rd_take = bus_sel_i & ~bus_wr_i;
   assign bmask = lane_mask(bus_size_i, bus_addr_i[1:0]);
   assign merged = (regs_ff[widx] & ~bmask) | (bus_wdata_i & bmask);
   assign prot_ok = regs_ff[cfr_pkg::OFS_CORE_CTRL[7:2]][cfr_pkg::CC_INIT]
                  & regs_ff[cfr_pkg::OFS_CORE_CTRL[7:2]][cfr_pkg::CC_CCE];

   // ----------------------------------------------------------------
   // Stored registers
   // ----------------------------------------------------------------
   logic [31:0] cc_now;
   logic [31:0] nxt_cc;

   assign cc_now = regs_ff[cfr_pkg::OFS_CORE_CTRL[7:2]];

   always_comb
   begin
      nxt_cc = prot_ok ? merged : cc_now;
      nxt_cc[cfr_pkg::CC_INIT] = merged[cfr_pkg::CC_INIT];
      nxt_cc[cfr_pkg::CC_CCE] = cc_now[cfr_pkg::CC_INIT] & merged[cfr_pkg::CC_CCE]
                              & merged[cfr_pkg::CC_INIT];
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < cfr_pkg::WORDS; i++)
         begin
            regs_ff[i] <= rst_val(8'(i * 4));
         end
      end
      else if (wr_take)
      begin
         if (wofs == cfr_pkg::OFS_CORE_CTRL)
         begin
            regs_ff[widx] <= nxt_cc;
         end
         else if (is_plain_rw(wofs) || (is_protected(wofs) && prot_ok))
         begin
            regs_ff[widx] <= merged;
         end
      end
   end

   // ----------------------------------------------------------------
   // Protocol-domain synchronisers
   // ----------------------------------------------------------------
   cfr_pkg::cfr_status_t st_meta_ff;
   cfr_pkg::cfr_status_t st_ff;
   logic [2:0] tgl_meta_ff;
   logic [2:0] tgl_ff;
   logic [2:0] tgl_old_ff;
   logic [2:0] tgl_evt;
   logic [31:0] hs_meta_ff [HS_WORDS];
   logic [31:0] hs_ff [HS_WORDS];

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_meta_ff <= '0;
         st_ff <= '0;
         tgl_meta_ff <= 3'h0;
         tgl_ff <= 3'h0;
         tgl_old_ff <= 3'h0;
      end
      else
      begin
         st_meta_ff <= proto_status_i;
         st_ff <= st_meta_ff;
         tgl_meta_ff <= {proto_errlog_tgl_i, proto_dlec_tgl_i, proto_lec_tgl_i};
         tgl_ff <= tgl_meta_ff;
         tgl_old_ff <= tgl_ff;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < HS_WORDS; i++)
         begin
            hs_meta_ff[i] <= 32'h0000_0000;
            hs_ff[i] <= 32'h0000_0000;
         end
      end
      else
      begin
         for (int i = 0; i < HS_WORDS; i++)
         begin
            hs_meta_ff[i] <= handler_word_i[i];
            hs_ff[i] <= hs_meta_ff[i];
         end
      end
   end

   assign tgl_evt = tgl_ff ^ tgl_old_ff;

   // ----------------------------------------------------------------
   // Read-effect fields
   // ----------------------------------------------------------------
   logic [2:0] lec_ff;
   logic [2:0] dlec_ff;
   logic [7:0] errlog_ff;
   logic rd_psr;
   logic rd_ecr;

   assign rd_psr = rd_take && (wofs == cfr_pkg::OFS_PROT_STAT);
   assign rd_ecr = rd_take && (wofs == cfr_pkg::OFS_ERR_CNT);

   // Updates win over the read that would clear them
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         lec_ff <= cfr_pkg::LEC_NO_CHANGE;
         dlec_ff <= cfr_pkg::LEC_NO_CHANGE;
      end
      else
      begin
         if (tgl_evt[0])
            lec_ff <= proto_lec_i;
         else if (rd_psr)
            lec_ff <= cfr_pkg::LEC_NO_CHANGE;
         if (tgl_evt[1])
            dlec_ff <= proto_dlec_i;
         else if (rd_psr)
            dlec_ff <= cfr_pkg::LEC_NO_CHANGE;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         errlog_ff <= 8'h00;
      else if (tgl_evt[2])
         errlog_ff <= rd_ecr ? 8'h01 : errlog_ff + ((errlog_ff != 8'hff) ? 8'h01 : 8'h00);
      else if (rd_ecr)
         errlog_ff <= 8'h00;
   end

   // ----------------------------------------------------------------
   // Timestamp and timeout counters
   // ----------------------------------------------------------------
   logic [15:0] ts_ff;
   logic [15:0] to_ff;
   logic [31:0] ts_cfg;
   logic [31:0] to_cfg;

   assign ts_cfg = regs_ff[cfr_pkg::OFS_TS_CFG[7:2]];
   assign to_cfg = regs_ff[cfr_pkg::OFS_TO_CFG[7:2]];

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ts_ff <= 16'h0000;
      else if (wr_take && wofs == cfr_pkg::OFS_TS_VAL)
         ts_ff <= 16'h0000;
      else if (ts_tick_i && ts_cfg[cfr_pkg::TS_SEL_LSB +: 2] == cfr_pkg::TS_SEL_INC)
         ts_ff <= ts_ff + 16'h0001;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         to_ff <= cfr_pkg::RST_TO_VAL;
      else if (wr_take && wofs == cfr_pkg::OFS_TO_VAL)
         to_ff <= to_cfg[cfr_pkg::TO_PERIOD_LSB +: 16];
      else if (to_tick_i && to_cfg[cfr_pkg::TO_EN] && to_ff != 16'h0000)
         to_ff <= to_ff - 16'h0001;
   end

   // ----------------------------------------------------------------
   // Interrupt flags and lines
   // ----------------------------------------------------------------
   logic [31:0] irq_ff;
   logic [31:0] irq_act;
   logic [31:0] ils;
   logic [31:0] ile;

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_ff <= 32'h0000_0000;
      else if (wr_take && wofs == cfr_pkg::OFS_IRQ_FLAGS)
         irq_ff <= (irq_ff & ~(bus_wdata_i & bmask)) | irq_event_i;
      else
         irq_ff <= irq_ff | irq_event_i;
   end

   assign irq_act = irq_ff & regs_ff[cfr_pkg::OFS_IRQ_EN[7:2]];
   assign ils = regs_ff[cfr_pkg::OFS_IRQ_SEL[7:2]];
   assign ile = regs_ff[cfr_pkg::OFS_IRQ_LINE_EN[7:2]];

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         irq_line_a_o <= 1'b0;
         irq_line_b_o <= 1'b0;
      end
      else
      begin
         irq_line_a_o <= ile[cfr_pkg::ILE_LINE_A] & |(irq_act & ~ils);
         irq_line_b_o <= ile[cfr_pkg::ILE_LINE_B] & |(irq_act & ils);
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [31:0] rd_word;

   always_comb
   begin
      case (wofs)
         cfr_pkg::OFS_RELEASE: rd_word = RELEASE_INFO;
         cfr_pkg::OFS_PROBE: rd_word = cfr_pkg::PROBE_WORD;
         cfr_pkg::OFS_TS_VAL: rd_word = {16'h0000, ts_ff};
         cfr_pkg::OFS_TO_VAL: rd_word = {16'h0000, to_ff};
         cfr_pkg::OFS_ERR_CNT: rd_word = {8'h00, errlog_ff, st_ff.rx_passive,
                                          st_ff.rx_err, st_ff.tx_err};
         cfr_pkg::OFS_PROT_STAT: rd_word = {21'h000000, dlec_ff, st_ff.bus_off,
                                            st_ff.warning, st_ff.passive,
                                            st_ff.activity, lec_ff};
         cfr_pkg::OFS_IRQ_FLAGS: rd_word = irq_ff;
         cfr_pkg::OFS_HPMS: rd_word = hs_ff[0];
         cfr_pkg::OFS_RXQ0_STAT: rd_word = hs_ff[1];
         cfr_pkg::OFS_RXQ1_STAT: rd_word = hs_ff[2];
         cfr_pkg::OFS_TXQ_STAT: rd_word = hs_ff[3];
         cfr_pkg::OFS_TX_PEND: rd_word = hs_ff[4];
         cfr_pkg::OFS_TX_DONE: rd_word = hs_ff[5];
         cfr_pkg::OFS_TX_CDONE: rd_word = hs_ff[6];
         cfr_pkg::OFS_TXEQ_STAT: rd_word = hs_ff[7];
         default:
         begin
            if (is_protected(wofs) || is_plain_rw(wofs) || wofs == cfr_pkg::OFS_CORE_CTRL)
               rd_word = regs_ff[widx];
            else
               rd_word = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         bus_rdata_o <= 32'h0000_0000;
         bus_rvalid_o <= 1'b0;
      end
      else
      begin
         bus_rvalid_o <= rd_take;
         if (rd_take)
            bus_rdata_o <= rd_word;
      end
   end

   // ----------------------------------------------------------------
   // Outputs toward the protocol engine
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         tx_add_pulse_o <= 32'h0000_0000;
      else if (wr_take && wofs == cfr_pkg::OFS_TX_ADD)
         tx_add_pulse_o <= bus_wdata_i & bmask;
      else
         tx_add_pulse_o <= 32'h0000_0000;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         bus_transmit_pin_o <= 1'b1;
      else
         bus_transmit_pin_o <= cc_now[cfr_pkg::CC_INIT] | proto_tx_i;
   end

   assign cfg_o.init = cc_now[cfr_pkg::CC_INIT];
   assign cfg_o.cfg_change = cc_now[cfr_pkg::CC_CCE];
   assign cfg_o.core_ctrl = cc_now;
   assign cfg_o.nom_bt = regs_ff[cfr_pkg::OFS_NOM_BT[7:2]];
   assign cfg_o.fast_bt = regs_ff[cfr_pkg::OFS_FAST_BT[7:2]];
   assign cfg_o.test = regs_ff[cfr_pkg::OFS_TEST[7:2]];
   assign cfg_o.tdc = regs_ff[cfr_pkg::OFS_TDC[7:2]];
   assign cfg_o.timestamp = ts_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_pin_recessive_init: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      $past(cc_now[cfr_pkg::CC_INIT]) |-> bus_transmit_pin_o)
      else $error("Transmit pin dominant while init set");

   a_probe_readback: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      rd_take && wofs == cfr_pkg::OFS_PROBE |=> bus_rdata_o == 32'h8765_4321)
      else $error("Probe word wrong");

   a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      rd_take && (wofs == 8'h08 || wofs == 8'h3c) |=> bus_rvalid_o && bus_rdata_o == 32'h0000_0000)
      else $error("Reserved read not zero");

   a_protect_block: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wr_take && wofs == cfr_pkg::OFS_FAST_BT && !prot_ok
      |=> $stable(regs_ff[cfr_pkg::OFS_FAST_BT[7:2]]))
      else $error("Protected write got through");

   a_protect_pass: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wr_take && wofs == cfr_pkg::OFS_NOM_BT && prot_ok
      && bus_size_i == cfr_pkg::CFR_SZ_WORD
      |=> regs_ff[cfr_pkg::OFS_NOM_BT[7:2]] == $past(bus_wdata_i))
      else $error("Enabled protected write lost");

   a_lane_keep: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wr_take && wofs == cfr_pkg::OFS_IRQ_EN && bus_size_i == cfr_pkg::CFR_SZ_BYTE
      && bus_addr_i[1:0] == 2'h0
      |=> regs_ff[cfr_pkg::OFS_IRQ_EN[7:2]][31:8] == $past(regs_ff[cfr_pkg::OFS_IRQ_EN[7:2]][31:8]))
      else $error("Byte write touched other lanes");

   a_lec_read_set: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      rd_psr && !tgl_evt[0] |=> lec_ff == 3'h7)
      else $error("Read did not set last error code");

   a_ts_write_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wr_take && wofs == cfr_pkg::OFS_TS_VAL |=> ts_ff == 16'h0000)
      else $error("Timestamp not cleared by write");

   a_line_a_route: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      ils == 32'h0000_0000 && ile[0] && |irq_act |=> irq_line_a_o && !irq_line_b_o)
      else $error("Default routing not on line A");

   a_read_latency: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      rd_take |=> bus_rvalid_o ##1 !bus_rvalid_o || $past(rd_take))
      else $error("Read answer timing wrong");

endmodule

// *** test/cfr_host.sv ***
// Host processor model driving the register bank's slave port.
// Assumes its task is called from one bench process, never twice at once.
`timescale 1ns/1ps
module cfr_host (
   input wire logic core_clk_i,
   input wire logic rvalid_i,
   input wire logic [31:0] rdata_i,
   output logic sel_o,
   output logic wr_o,
   output logic [7:0] addr_o,
   output cfr_pkg::cfr_size_t size_o,
   output logic [31:0] wdata_o
);
   initial
   begin
      sel_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'h00;
      size_o = cfr_pkg::CFR_SZ_WORD;
      wdata_o = 32'h0;
   end

   // One access; idle address and data lines get the inverse so stale values never match
   task automatic acc(input logic w, input logic [7:0] a, input cfr_pkg::cfr_size_t s,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk_i);
      sel_o <= 1'b1;
      wr_o <= w;
      addr_o <= a;
      size_o <= s;
      wdata_o <= d;
      @(posedge core_clk_i);
      sel_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      @(negedge core_clk_i);
      q = (!w && rvalid_i === 1'b1) ? rdata_i : 32'hxxxx_xxxx;
   endtask
endmodule

// *** test/test_cfr_regbank.sv ***
// Self-checking bench for the host register bank.
// Assumes cfr_pkg is compiled first; the host model drives the slave port.
`timescale 1ns/1ps
module test_cfr_regbank;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic sel, wr, rvalid, pin, lec_tgl = 1'b0, log_tgl = 1'b0, ts_t = 1'b0, to_t = 1'b0;
   logic ptx = 1'b1;
   logic irqa, irqb;
   logic [31:0] txp, irq_ev = 32'h0;
   cfr_pkg::cfr_cfg_t cfg;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [2:0] lec = 3'h3;
   logic [31:0] hw [8] = '{default: 32'h0};
   cfr_pkg::cfr_size_t size;
   cfr_pkg::cfr_status_t st = '0;
   int errors = 0;
   int total_checks = 0;
   always #4 core_clk_i = ~core_clk_i;
   cfr_host cfr_host_inst (.core_clk_i(core_clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
      .sel_o(sel), .wr_o(wr), .addr_o(addr), .size_o(size), .wdata_o(wdata));
   cfr_regbank cfr_regbank_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus_sel_i(sel),
      .bus_wr_i(wr), .bus_addr_i(addr), .bus_size_i(size), .bus_wdata_i(wdata),
      .bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .proto_status_i(st), .proto_lec_i(lec),
      .proto_lec_tgl_i(lec_tgl), .proto_dlec_i(3'h0), .proto_dlec_tgl_i(1'b0),
      .proto_errlog_tgl_i(log_tgl), .handler_word_i(hw), .irq_event_i(irq_ev),
      .ts_tick_i(ts_t), .to_tick_i(to_t), .proto_tx_i(ptx), .bus_transmit_pin_o(pin),
      .irq_line_a_o(irqa), .irq_line_b_o(irqb), .tx_add_pulse_o(txp), .cfg_o(cfg));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr_r(input logic [7:0] a, input logic [31:0] d, input cfr_pkg::cfr_size_t s);
      cfr_host_inst.acc(1'b1, a, s, d, q);
   endtask
   task automatic rd_r(input logic [7:0] a, input logic [31:0] e);
      cfr_host_inst.acc(1'b0, a, cfr_pkg::CFR_SZ_WORD, 32'h0, q);
      chk(q, e);
   endtask
   task automatic tick(input logic sel_to, input int n);
      @(posedge core_clk_i);
      if (sel_to)
         to_t <= 1'b1;
      else
         ts_t <= 1'b1;
      repeat (n) @(posedge core_clk_i);
      ts_t <= 1'b0;
      to_t <= 1'b0;
   endtask
   task automatic finish_test();
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_r(8'h04, 32'h8765_4321);
      rd_r(8'h18, 32'h0000_0001);
      rd_r(8'h1c, 32'h0600_0a03);
      rd_r(8'h2c, 32'h0000_ffff);
      rd_r(8'h44, 32'h0000_0707);
      rd_r(8'h3c, 32'h0);
      chk({31'h0, pin}, 32'h1);
      chk(cfg.nom_bt, 32'h0600_0a03);
   endtask
   task automatic t_protect();
      wr_r(8'h0c, 32'h0, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h0c, 32'h0000_0a33);
      wr_r(8'h18, 32'h3, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h18, 32'h3);
      wr_r(8'h1c, 32'h0123_4567, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h1c, 32'h0123_4567);
      wr_r(8'h0d, 32'h0000_5500, cfr_pkg::CFR_SZ_BYTE);
      wr_r(8'h0e, 32'h0001_0000, cfr_pkg::CFR_SZ_HALF);
      rd_r(8'h0c, 32'h0001_5533);
      wr_r(8'h08, 32'hffff_ffff, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h08, 32'h0);
   endtask
   task automatic t_irq();
      wr_r(8'h54, 32'hffff_ffff, cfr_pkg::CFR_SZ_WORD);
      wr_r(8'h54, 32'h0000_0012, cfr_pkg::CFR_SZ_BYTE);
      rd_r(8'h54, 32'hffff_ff12);
      wr_r(8'h5c, 32'h1, cfr_pkg::CFR_SZ_WORD);
      @(posedge core_clk_i);
      irq_ev <= 32'h2;
      @(posedge core_clk_i);
      irq_ev <= 32'h0;
      repeat (2) @(negedge core_clk_i);
      chk({30'h0, irqb, irqa}, 32'h1);
      wr_r(8'h58, 32'h2, cfr_pkg::CFR_SZ_WORD);
      wr_r(8'h5c, 32'h3, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h50, 32'h2);
      chk({30'h0, irqb, irqa}, 32'h2);
      wr_r(8'hd1, 32'h0000_ff00, cfr_pkg::CFR_SZ_BYTE);
      chk(txp, 32'h0000_ff00);
   endtask
   task automatic t_counters();
      wr_r(8'h20, 32'h1, cfr_pkg::CFR_SZ_WORD);
      tick(1'b0, 3);
      rd_r(8'h24, 32'h3);
      wr_r(8'h24, 32'h55, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h24, 32'h0);
      wr_r(8'h28, 32'hffff_0001, cfr_pkg::CFR_SZ_WORD);
      tick(1'b1, 2);
      rd_r(8'h2c, 32'h0000_fffd);
      wr_r(8'h2c, 32'h0, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h2c, 32'h0000_ffff);
   endtask
   task automatic t_read_fx();
      @(posedge core_clk_i);
      lec_tgl <= 1'b1;
      log_tgl <= 1'b1;
      hw[3] <= 32'h0000_0a5a;
      repeat (5) @(posedge core_clk_i);
      rd_r(8'hc4, 32'h0000_0a5a);
      rd_r(8'h44, 32'h0000_0703);
      rd_r(8'h44, 32'h0000_0707);
      rd_r(8'h40, 32'h0001_0000);
      rd_r(8'h40, 32'h0);
   endtask
   task automatic t_init_off();
      @(posedge core_clk_i);
      ptx <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk({31'h0, pin}, 32'h1);
      wr_r(8'h18, 32'h0, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h18, 32'h0);
      wr_r(8'h0c, 32'h0, cfr_pkg::CFR_SZ_WORD);
      rd_r(8'h0c, 32'h0001_5533);
      chk({31'h0, pin}, 32'h0);
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      t_reset();
      t_protect();
      t_irq();
      t_counters();
      t_read_fx();
      t_init_off();
      finish_test();
   end
endmodule
